// file: include/rso_defs.vh
`ifndef RSO_DEFS_VH
`define RSO_DEFS_VH
// =====================================================================
// frame geometry (zero-based row and column)
`define RSO_LAST_COL 15'd17279
`define RSO_LAST_ROW 4'd8
`define RSO_OH_ROWS 4'd3
`define RSO_OH_COLS 15'd576
`define RSO_SECOND_FRAMING_COL 15'd192
`define RSO_TRACE_COL 15'd384
`define RSO_DCC_TWO_COL 15'd192
`define RSO_DCC_THREE_COL 15'd384
`define RSO_PARITY_ROW 4'd1
`define RSO_DCC_ROW 4'd2
`define RSO_SCR_PRESET 7'h7f
// =====================================================================
// timing
`define RSO_CLK_PERIOD_NS 100
`define RSO_AIS_LIMIT_US 250
`define RSO_AIS_LIMIT_CYC (`RSO_AIS_LIMIT_US * 1000 / `RSO_CLK_PERIOD_NS)
`define RSO_FRAME_US 125
`define RSO_TRACE_PERSIST 2'd2
// =====================================================================
// register map
`define RSO_ADDR_CTRL 8'h00
`define RSO_ADDR_TX_TRACE 8'h04
`define RSO_ADDR_EXP_TRACE 8'h08
`define RSO_ADDR_ACC_TRACE 8'h0c
`define RSO_ADDR_STATUS 8'h10
`define RSO_ADDR_ERR_COUNT 8'h14
`define RSO_CTRL_MON_BIT 0
`define RSO_CTRL_TIM_DIS_BIT 1
`define RSO_CTRL_SSF_USE_BIT 2
`define RSO_CTRL_RESET 3'h5
`define RSO_ERR_MAX 16'hffff
`endif

// file: src/rso_top.v
`timescale 1ns/1ps
// Behaviour
// - insert first then second framing byte runs
// - write transmitted trace value into trace byte
// - parity of previous scrambled frame into parity byte
// - scramble with 1+x6+x7 length 127
// - preset all ones at row 1 column 577
// - descrambler identical to transmit scrambler
// - compare received parity, flag block error
// - extract trace byte, present accepted trace value
// - mismatch defect from accepted versus expected trace
// - server fail or mismatch drives alarm and trail fail
// - receive output all ones under alarm
// - payload bytes fill payload positions
// - payload all ones while server fail active
// - all ones runs at frame byte rate
// - unconnected server fail treated as inactive
// - data channel bytes into three channel positions
// - sinks extract data, fail equals trail fail
// - octet stream framed, timing carried alongside
`include "rso_defs.vh"
module rso_top #(
  parameter [7:0] FIRST_FRAMING_VALUE = 8'hf6,
  parameter [7:0] SECOND_FRAMING_VALUE = 8'h28
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire i_tx_frame_start,
  input wire [7:0] i_tx_payload,
  input wire i_tx_server_fail,
  input wire [7:0] i_tx_dcc,
  output wire o_tx_payload_take,
  output wire o_tx_dcc_take,
  output reg [7:0] o_tx_data,
  output reg o_tx_frame_start,
  input wire i_rx_frame_start,
  input wire [7:0] i_rx_data,
  input wire i_rx_server_fail,
  output reg [7:0] o_rx_data,
  output reg o_rx_frame_start,
  output reg o_rx_payload_valid,
  output reg o_rx_dcc_valid,
  output reg o_rx_trail_fail,
  output reg o_rx_payload_fail,
  output reg o_rx_dcc_fail,
  output reg o_near_end_block_error,
  output wire [7:0] o_accepted_trace,
  output wire o_trace_mismatch_report
);

  // ===================================================================
  // scrambler step over one byte: {next state, keystream byte}
  function [14:0] rso_scr_step;
    input [6:0] st;
    reg [6:0] s;
    reg [7:0] ks;
    integer i;
    begin
      s = st;
      ks = 8'h00;
      for (i = 7; i >= 0; i = i - 1) begin
        ks[i] = s[6];
        s = {s[5:0], s[6] ^ s[5]};
      end
      rso_scr_step = {s, ks};
    end
  endfunction

  // ===================================================================
  // frame position counters, index 0 transmit, 1 receive
  wire [1:0] frame_start;
  wire [29:0] cur_col;
  wire [7:0] cur_row;
  assign frame_start = {i_rx_frame_start, i_tx_frame_start};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pos
      reg [14:0] col_reg;
      reg [3:0] row_reg;
      wire [14:0] col;
      wire [3:0] row;
      assign col = frame_start[g] ? 15'd0 : col_reg;
      assign row = frame_start[g] ? 4'd0 : row_reg;
      assign cur_col[g*15 +: 15] = col;
      assign cur_row[g*4 +: 4] = row;
      always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          col_reg <= 15'd0;
          row_reg <= 4'd0;
        end else if (col == `RSO_LAST_COL) begin
          col_reg <= 15'd0;
          row_reg <= (row == `RSO_LAST_ROW) ? 4'd0 : row + 4'd1;
        end else begin
          col_reg <= col + 15'd1;
          row_reg <= row;
        end
      end
    end
  endgenerate

  wire [14:0] tc = cur_col[14:0];
  wire [3:0] tr = cur_row[3:0];
  wire [14:0] rc = cur_col[29:15];
  wire [3:0] rr = cur_row[7:4];

  // ===================================================================
  // registers
  reg [2:0] ctrl_reg;
  reg [7:0] tx_trace_reg;
  reg [7:0] exp_trace_reg;
  reg [15:0] err_count_reg;
  reg [7:0] acc_trace_reg;
  reg trace_mismatch_defect;

  wire monitoring_active = ctrl_reg[`RSO_CTRL_MON_BIT];
  wire trace_mismatch_disable = ctrl_reg[`RSO_CTRL_TIM_DIS_BIT];
  wire ssf_use = ctrl_reg[`RSO_CTRL_SSF_USE_BIT];

  // ===================================================================
  // transmit: overhead insertion, payload and channel adaptation
  wire tx_first = (tr == 4'd0) && (tc == 15'd0);
  wire tx_in_oh = (tr < `RSO_OH_ROWS) && (tc < `RSO_OH_COLS);
  wire tx_unscr = (tr == 4'd0) && (tc < `RSO_OH_COLS);
  wire tx_dcc_pos = (tr == `RSO_DCC_ROW) &&
    ((tc == 15'd0) || (tc == `RSO_DCC_TWO_COL) ||
     (tc == `RSO_DCC_THREE_COL));
  wire tx_preset = (tr == 4'd0) && (tc == `RSO_OH_COLS);
  // server fail counts only when marked connected
  wire server_fail_action = i_tx_server_fail & ssf_use;

  assign o_tx_payload_take = !tx_in_oh;
  assign o_tx_dcc_take = tx_dcc_pos;

  reg [6:0] tx_scr_reg;
  reg [7:0] tx_bip_acc_reg;
  reg [7:0] tx_bip_hold_reg;
  reg [7:0] tx_clear;
  wire [6:0] tx_scr_in = tx_preset ? `RSO_SCR_PRESET : tx_scr_reg;
  wire [14:0] tx_step = rso_scr_step(tx_scr_in);
  wire [7:0] tx_out = tx_unscr ? tx_clear : tx_clear ^ tx_step[7:0];

  always @* begin
    tx_clear = 8'h00;
    if (!tx_in_oh) begin
      if (server_fail_action)
        tx_clear = 8'hff;
      else
        tx_clear = i_tx_payload;
    end else if (tr == 4'd0) begin
      if (tc < `RSO_SECOND_FRAMING_COL)
        tx_clear = FIRST_FRAMING_VALUE;
      else if (tc < `RSO_TRACE_COL)
        tx_clear = SECOND_FRAMING_VALUE;
      else if (tc == `RSO_TRACE_COL)
        tx_clear = tx_trace_reg;
    end else if ((tr == `RSO_PARITY_ROW) && (tc == 15'd0)) begin
      tx_clear = tx_bip_hold_reg;
    end else if (tx_dcc_pos) begin
      tx_clear = i_tx_dcc;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_scr_reg <= `RSO_SCR_PRESET;
      tx_bip_acc_reg <= 8'h00;
      tx_bip_hold_reg <= 8'h00;
      o_tx_data <= 8'h00;
      o_tx_frame_start <= 1'b0;
    end else begin
      tx_scr_reg <= tx_step[14:8];
      tx_bip_acc_reg <= (tx_first ? 8'h00 : tx_bip_acc_reg) ^ tx_out;
      if (tx_first)
        tx_bip_hold_reg <= tx_bip_acc_reg;
      o_tx_data <= tx_out;
      o_tx_frame_start <= tx_first;
    end
  end

  // ===================================================================
  // receive: descramble, parity check, trace, alarms, sinks
  wire rx_first = (rr == 4'd0) && (rc == 15'd0);
  wire rx_in_oh = (rr < `RSO_OH_ROWS) && (rc < `RSO_OH_COLS);
  wire rx_unscr = (rr == 4'd0) && (rc < `RSO_OH_COLS);
  wire rx_dcc_pos = (rr == `RSO_DCC_ROW) &&
    ((rc == 15'd0) || (rc == `RSO_DCC_TWO_COL) ||
     (rc == `RSO_DCC_THREE_COL));
  wire rx_preset = (rr == 4'd0) && (rc == `RSO_OH_COLS);
  wire rx_parity_pos = (rr == `RSO_PARITY_ROW) && (rc == 15'd0);
  wire rx_trace_pos = (rr == 4'd0) && (rc == `RSO_TRACE_COL);

  reg [6:0] rx_scr_reg;
  reg [7:0] rx_bip_acc_reg;
  reg [7:0] rx_bip_hold_reg;
  reg [7:0] rx_cand_reg;
  reg [1:0] rx_same_reg;
  wire [6:0] rx_scr_in = rx_preset ? `RSO_SCR_PRESET : rx_scr_reg;
  wire [14:0] rx_step = rso_scr_step(rx_scr_in);
  wire [7:0] rx_clear = rx_unscr ? i_rx_data :
    i_rx_data ^ rx_step[7:0];
  wire rx_block_err = rx_parity_pos &&
    ((rx_clear ^ rx_bip_hold_reg) != 8'h00);
  wire all_ones_insert_action = i_rx_server_fail |
    trace_mismatch_defect;
  wire trail_fail_action = all_ones_insert_action;

  assign o_accepted_trace = acc_trace_reg;
  assign o_trace_mismatch_report = monitoring_active &
    trace_mismatch_defect;

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_scr_reg <= `RSO_SCR_PRESET;
      rx_bip_acc_reg <= 8'h00;
      rx_bip_hold_reg <= 8'h00;
      rx_cand_reg <= 8'h00;
      rx_same_reg <= 2'd0;
      acc_trace_reg <= 8'h00;
      trace_mismatch_defect <= 1'b0;
      o_rx_data <= 8'h00;
      o_rx_frame_start <= 1'b0;
      o_rx_payload_valid <= 1'b0;
      o_rx_dcc_valid <= 1'b0;
      o_rx_trail_fail <= 1'b0;
      o_rx_payload_fail <= 1'b0;
      o_rx_dcc_fail <= 1'b0;
      o_near_end_block_error <= 1'b0;
    end else begin
      rx_scr_reg <= rx_step[14:8];
      // parity runs over the received, still scrambled bytes
      rx_bip_acc_reg <= (rx_first ? 8'h00 : rx_bip_acc_reg) ^ i_rx_data;
      if (rx_first)
        rx_bip_hold_reg <= rx_bip_acc_reg;
      o_near_end_block_error <= rx_block_err;
      // trace accepted after three equal frames in a row
      if (rx_trace_pos) begin
        rx_cand_reg <= rx_clear;
        if (rx_clear != rx_cand_reg) begin
          // any change restarts the run of equal sightings
          rx_same_reg <= 2'd0;
        end else begin
          // third equal sighting in a row takes the value
          if (rx_same_reg == (`RSO_TRACE_PERSIST - 2'd1))
            acc_trace_reg <= rx_clear;
          // run count saturates, so a steady trace stays accepted
          if (rx_same_reg != `RSO_TRACE_PERSIST)
            rx_same_reg <= rx_same_reg + 2'd1;
        end
      end
      trace_mismatch_defect <= !trace_mismatch_disable &&
        (acc_trace_reg != exp_trace_reg);
      o_rx_data <= all_ones_insert_action ? 8'hff : rx_clear;
      o_rx_frame_start <= rx_first;
      o_rx_payload_valid <= !rx_in_oh;
      o_rx_dcc_valid <= rx_dcc_pos;
      o_rx_trail_fail <= trail_fail_action;
      o_rx_payload_fail <= trail_fail_action;
      o_rx_dcc_fail <= trail_fail_action;
    end
  end

  // ===================================================================
  // register bus
  wire err_clr = i_wr && (i_addr == `RSO_ADDR_ERR_COUNT);

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg <= `RSO_CTRL_RESET;
      tx_trace_reg <= 8'h00;
      exp_trace_reg <= 8'h00;
      err_count_reg <= 16'h0000;
    end else begin
      if (i_wr && (i_addr == `RSO_ADDR_CTRL))
        ctrl_reg <= i_wdata[2:0];
      if (i_wr && (i_addr == `RSO_ADDR_TX_TRACE))
        tx_trace_reg <= i_wdata[7:0];
      if (i_wr && (i_addr == `RSO_ADDR_EXP_TRACE))
        exp_trace_reg <= i_wdata[7:0];
      // a new error in the clearing cycle is kept
      if (o_near_end_block_error) begin
        if (err_clr)
          err_count_reg <= 16'h0001;
        else if (err_count_reg != `RSO_ERR_MAX)
          err_count_reg <= err_count_reg + 16'h0001;
      end else if (err_clr) begin
        err_count_reg <= 16'h0000;
      end
    end
  end

  // ===================================================================
  // read word selection, unmapped offsets read zero
  reg [31:0] rd_word;

  always @* begin
    rd_word = 32'h00000000;
    case (i_addr)
      `RSO_ADDR_CTRL: rd_word = {29'h0, ctrl_reg};
      `RSO_ADDR_TX_TRACE: rd_word = {24'h0, tx_trace_reg};
      `RSO_ADDR_EXP_TRACE: rd_word = {24'h0, exp_trace_reg};
      `RSO_ADDR_ACC_TRACE: rd_word = {24'h0, acc_trace_reg};
      `RSO_ADDR_STATUS: rd_word = {28'h0, server_fail_action,
        o_rx_trail_fail, o_trace_mismatch_report, trace_mismatch_defect};
      `RSO_ADDR_ERR_COUNT: rd_word = {16'h0, err_count_reg};
      default: rd_word = 32'h00000000;
    endcase
  end

  // read data stands for the one cycle after the strobe only
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      o_rdata <= rd_word;
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

endmodule

// file: sim/rso_line_model.sv
`timescale 1ns/1ps
// =====================================================================
// line side loopback, one byte of delay
module rso_line_model (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_line_data,
  input wire logic i_line_start,
  output logic [7:0] o_line_data,
  output logic o_line_start
);
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_line_data <= 8'h00;
      o_line_start <= 1'b0;
    end else begin
      o_line_data <= i_line_data;
      o_line_start <= i_line_start;
    end
  end
endmodule

// file: sim/rso_top_assertions.sv
`timescale 1ns/1ps
// =====================================================================
// port checker
module rso_checker #(
  parameter [7:0] FIRST_FRAMING_VALUE = 8'hf6,
  parameter [7:0] SECOND_FRAMING_VALUE = 8'h28
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire i_rd,
  input wire [31:0] o_rdata,
  input wire i_tx_frame_start,
  input wire o_tx_payload_take,
  input wire o_tx_dcc_take,
  input wire [7:0] o_tx_data,
  input wire o_tx_frame_start,
  input wire i_rx_server_fail,
  input wire [7:0] o_rx_data,
  input wire o_rx_trail_fail,
  input wire o_rx_payload_fail,
  input wire o_rx_dcc_fail,
  input wire o_near_end_block_error,
  input wire o_trace_mismatch_report
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  chk_start_align: assert property (
    i_tx_frame_start |=> o_tx_frame_start)
    else $error("tx frame start not carried");
  chk_first_framing: assert property (
    i_tx_frame_start |=> o_tx_data == FIRST_FRAMING_VALUE)
    else $error("first framing byte wrong");
  chk_second_framing: assert property (
    i_tx_frame_start |-> ##193 o_tx_data == SECOND_FRAMING_VALUE)
    else $error("second framing byte wrong");
  chk_take_quiet: assert property (
    i_tx_frame_start |-> !o_tx_payload_take && !o_tx_dcc_take)
    else $error("take at overhead position");
  chk_fail_equal: assert property (
    o_rx_payload_fail == o_rx_trail_fail && o_rx_dcc_fail == o_rx_trail_fail)
    else $error("sink fail differs from trail fail");
  chk_ssf_trail: assert property (
    i_rx_server_fail |=> o_rx_trail_fail)
    else $error("server fail not passed on");
  chk_report_trail: assert property (
    o_trace_mismatch_report |=> o_rx_trail_fail)
    else $error("mismatch without trail fail");
  chk_rx_all_ones: assert property (
    o_rx_trail_fail && $past(o_rx_trail_fail) |-> o_rx_data == 8'hff)
    else $error("rx data not all ones");
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside read slot");
  chk_block_pulse: assert property (
    o_near_end_block_error |=> !o_near_end_block_error)
    else $error("block error not a pulse");
  cover property (i_tx_frame_start);
  cover property (o_rx_trail_fail);
  cover property (o_trace_mismatch_report);
endmodule
bind rso_top rso_checker #(.FIRST_FRAMING_VALUE(FIRST_FRAMING_VALUE),
  .SECOND_FRAMING_VALUE(SECOND_FRAMING_VALUE)) rso_checker_inst (.*);

// file: sim/rso_top_tb_top.sv
`timescale 1ns/1ps
module rso_top_tb_top;
  logic i_ref_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0;
  logic [7:0] i_addr = 0, i_tx_payload = 0, i_tx_dcc = 0;
  logic [31:0] i_wdata = 0, seed = 32'h566d;
  logic i_tx_frame_start = 0, i_tx_server_fail = 0, i_rx_server_fail = 0;
  wire [31:0] o_rdata;
  wire [7:0] o_tx_data, o_rx_data, o_accepted_trace, i_rx_data;
  wire o_tx_payload_take, o_tx_dcc_take, o_tx_frame_start, i_rx_frame_start;
  wire o_rx_frame_start, o_rx_payload_valid, o_rx_dcc_valid, o_rx_trail_fail;
  wire o_rx_payload_fail, o_rx_dcc_fail, o_near_end_block_error;
  wire o_trace_mismatch_report;
  int n_errors = 0, checks = 0;
  logic [31:0] q_rd[$];
  logic [7:0] q_tx[$], q_rx[$];
  logic [1:0] q_rf[$];
  logic q_tf[$];
  logic rd_d = 0, tx_run = 0, r1 = 0, r2 = 0, r3 = 0;
  rso_top rso_top_inst (.*);
  rso_line_model rso_line_model_inst (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_line_data(o_tx_data),
    .i_line_start(o_tx_frame_start), .o_line_data(i_rx_data),
    .o_line_start(i_rx_frame_start));
  initial forever #50 i_ref_clk = ~i_ref_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 0;
    repeat (3) @(posedge i_ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1;
    i_addr <= a;
    q_rd.push_back(e);
    @(posedge i_ref_clk);
    i_rd <= 0;
  endtask
  // =====================================================================
  // result watcher
  always @(posedge i_ref_clk) begin
    rd_d <= i_rd;
    r1 <= tx_run;
    r2 <= r1;
    r3 <= r2;
  end
  always @(negedge i_ref_clk) begin
    if (rd_d) chk(o_rdata, q_rd.pop_front());
    if (r1) chk({24'h0, o_tx_data}, {24'h0, q_tx.pop_front()});
    if (r3) chk({24'h0, o_rx_data}, {24'h0, q_rx.pop_front()});
    if (r1) chk({31'h0, o_tx_frame_start}, {31'h0, q_tf.pop_front()});
    if (r3) chk({30'h0, o_rx_frame_start, o_rx_payload_valid},
      {30'h0, q_rf.pop_front()});
  end
  // =====================================================================
  // one partial frame from frame start into the scrambled payload
  task automatic frame(input logic [31:0] ctl, input logic fail);
    logic [6:0] s;
    logic [7:0] b, k;
    int c, i;
    s = 7'h7f;
    wr(8'h00, ctl);
    i_tx_server_fail <= fail;
    for (c = 0; c < 600; c++) begin
      @(posedge i_ref_clk);
      seed = lfsr(seed);
      i_tx_frame_start <= (c == 0);
      i_tx_payload <= seed[7:0];
      i_tx_dcc <= seed[15:8];
      tx_run <= 1;
      k = 0;
      if (c < 192) b = 8'hf6;
      else if (c < 384) b = 8'h28;
      else if (c == 384) b = 8'h3c;
      else if (c < 576) b = 0;
      else begin
        b = (fail && ctl[2]) ? 8'hff : seed[7:0];
        for (i = 7; i >= 0; i--) begin
          k[i] = s[6];
          s = {s[5:0], s[6] ^ s[5]};
        end
      end
      q_tx.push_back(b ^ k);
      q_rx.push_back(b);
      q_tf.push_back(c == 0);
      q_rf.push_back({c == 0, c >= 576});
    end
    @(posedge i_ref_clk);
    tx_run <= 0;
    repeat (4) @(posedge i_ref_clk);
  endtask
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_rst_n <= 1;
    rd(8'h00, 32'h5);
    rd(8'h20, 32'h0);
    wr(8'h0c, 32'hff);
    rd(8'h0c, 32'h0);
    rd(8'h14, 32'h0);
    wr(8'h04, 32'h3c);
    wr(8'h08, 32'h3c);
    rd(8'h04, 32'h3c);
    $display("test registers done");
    frame(32'h7, 0);
    frame(32'h7, 1);
    frame(32'h3, 1);
    i_tx_server_fail <= 0;
    rd(8'h0c, 32'h3c);
    chk({24'h0, o_accepted_trace}, 32'h3c);
    $display("test frames done");
    wr(8'h00, 32'h5);
    rd(8'h10, 32'h0);
    wr(8'h08, 32'hc3);
    rd(8'h10, 32'h7);
    wr(8'h00, 32'h4);
    rd(8'h10, 32'h5);
    wr(8'h00, 32'h6);
    rd(8'h10, 32'h0);
    i_rx_server_fail <= 1;
    i_tx_server_fail <= 1;
    repeat (4) @(posedge i_ref_clk);
    rd(8'h10, 32'hc);
    i_rx_server_fail <= 0;
    i_tx_server_fail <= 0;
    repeat (4) @(posedge i_ref_clk);
    rd(8'h10, 32'h0);
    $display("test alarms done");
    repeat (4) @(posedge i_ref_clk);
    conclude();
  end
  initial begin
    #(100 * 20000);
    n_errors++;
    conclude();
  end
endmodule
